/* rtl/ssp_top.sv */
// Synchronous serial port: APB register file, master clock engine,
// shared shift logic for master and slave, sticky interrupt flags.
// Assumes pins are resolved outside from the out and oe signals.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Word length is programmable from one to sixteen bits.
// - Master drives the shift clock; slave takes it from outside.
// - 125 rate settings, fastest is processor clock over four.
// - Polarity and phase bits pick one of four clocking schemes.
// - Falling scheme, no delay: change on falling, sample on rising.
// - Falling scheme, delay: bit set half cycle early, sample falling.
// - Rising scheme, no delay: idle low, change rising, sample falling.
// - Rising scheme, delay: idle low, bit early, sample rising edge.
// - Receive and transmit together; transmit can be switched off.
// - Done flags for transmit and receive, polled or by interrupt.
// - Nine registers in a frame based at 7040h.
// - Contents in bits 7 to 0; upper bits read zero, writes ignored.
// - Data lines change direction between master and slave.
// - Slave never drives its output while transmit enable is off.
// - Unused port releases all four pins for general use.
// - Port enable is cleared at reset; port idles until set.
module ssp_top #(
    parameter int RATE_STEPS = 125
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Serial pins
    input wire logic serial_shift_clock_in,
    output logic serial_shift_clock_out,
    output logic serial_shift_clock_oe,
    input wire logic slave_in_master_out_in,
    output logic slave_in_master_out_out,
    output logic slave_in_master_out_oe,
    input wire logic slave_out_master_in_in,
    output logic slave_out_master_in_out,
    output logic slave_out_master_in_oe,
    input wire logic slave_transmit_enable_n,
    // Pin mux: low hands pins to general-purpose use
    output logic port_in_use
);
    import ssp_pkg::*;

    // Refuse a rate table that the 7-bit setting cannot hold
    if (RATE_STEPS < 1 || RATE_STEPS > 128)
    begin : g_bad_rate
        $error("RATE_STEPS must lie in 1 to 128");
    end

    // Address hit on one register of the frame
    function automatic logic hit(input logic [15:0] a, input logic [5:0] o);
        return a == (FRAME_BASE + {10'h000, o});
    endfunction

    // Left-align a word so its first bit sits at bit 15
    function automatic logic [15:0] align(input logic [15:0] w,
                                          input logic [3:0] lm1);
        return w << (4'hF - lm1);
    endfunction

    ssp_ctrl_t ctrl;
    logic [3:0] len_m1;
    logic [6:0] rate;
    logic [15:0] tx_data;
    logic [15:0] rx_data;
    logic [1:0] status;
    logic [1:0] mask;
    logic [1:0] stat_cap;
    logic [7:0] rd_byte;
    logic mapped;
    logic setup;
    logic access;
    logic wr;
    ssp_state_t state;
    logic busy;
    logic [7:0] half_cnt;
    logic [7:0] half_len;
    logic [6:0] rate_eff;
    logic [4:0] edge_cnt;
    logic [4:0] edge_last;
    logic sclk_lvl;
    logic [15:0] tx_sr;
    logic [15:0] rx_sr;
    logic [3:0] bit_cnt;
    logic out_bit;
    logic [1:0] sclk_s;
    logic [1:0] simo_s;
    logic [1:0] somi_s;
    logic [1:0] ste_s;
    logic sclk_prev;
    logic ste_prev;
    logic master_on;
    logic slave_on;
    logic tick;
    logic m_lead;
    logic m_trail;
    logic s_edge;
    logic lead;
    logic trail;
    logic sample;
    logic present;
    logic start;
    logic tx_load;
    logic slave_begin;
    logic din;
    logic word_done;
    logic [15:0] next_word;
    logic m_samp_d;

    // Two-stage synchronisers on every pin input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_s <= 2'h0;
            simo_s <= 2'h0;
            somi_s <= 2'h0;
            ste_s <= 2'h3;
        end
        else
        begin
            sclk_s <= {sclk_s[0], serial_shift_clock_in};
            simo_s <= {simo_s[0], slave_in_master_out_in};
            somi_s <= {somi_s[0], slave_out_master_in_in};
            ste_s <= {ste_s[0], slave_transmit_enable_n};
        end
    end

    // Previous synchronised levels for edge finding
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_prev <= 1'b0;
            ste_prev <= 1'b1;
        end
        else
        begin
            sclk_prev <= sclk_s[1];
            ste_prev <= ste_s[1];
        end
    end

    // APB phases and frame decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign pready = 1'b1;
    assign mapped = hit(paddr, OFS_CTRL) | hit(paddr, OFS_LEN) |
                    hit(paddr, OFS_RATE) | hit(paddr, OFS_TXLO) |
                    hit(paddr, OFS_TXHI) | hit(paddr, OFS_RXLO) |
                    hit(paddr, OFS_RXHI) | hit(paddr, OFS_STAT) |
                    hit(paddr, OFS_MASK);

    // Read multiplexer, one byte per register
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(paddr, OFS_CTRL))
            rd_byte = ctrl;
        else if (hit(paddr, OFS_LEN))
            rd_byte = {4'h0, len_m1};
        else if (hit(paddr, OFS_RATE))
            rd_byte = {1'b0, rate};
        else if (hit(paddr, OFS_TXLO))
            rd_byte = tx_data[7:0];
        else if (hit(paddr, OFS_TXHI))
            rd_byte = tx_data[15:8];
        else if (hit(paddr, OFS_RXLO))
            rd_byte = rx_data[7:0];
        else if (hit(paddr, OFS_RXHI))
            rd_byte = rx_data[15:8];
        else if (hit(paddr, OFS_STAT))
            rd_byte = {5'h00, busy, status};
        else if (hit(paddr, OFS_MASK))
            rd_byte = {6'h00, mask};
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            stat_cap <= 2'h0;
        end
        else if (setup)
        begin
            prdata <= {24'h00_0000, rd_byte};
            pslverr <= ~mapped;
            stat_cap <= (!pwrite && hit(paddr, OFS_STAT)) ? status : 2'h0;
        end
    end

    // Software-written registers; only the low byte is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RST;
            len_m1 <= LEN_RST;
            rate <= RATE_RST;
            mask <= MASK_RST;
            tx_data <= 16'h0000;
        end
        else if (wr)
        begin
            if (hit(paddr, OFS_CTRL))
                ctrl <= {3'h0, pwdata[4:0]};
            if (hit(paddr, OFS_LEN))
                len_m1 <= pwdata[3:0];
            if (hit(paddr, OFS_RATE))
                rate <= pwdata[6:0];
            if (hit(paddr, OFS_MASK))
                mask <= pwdata[1:0];
            if (hit(paddr, OFS_TXLO))
                tx_data[7:0] <= pwdata[7:0];
            if (hit(paddr, OFS_TXHI))
                tx_data[15:8] <= pwdata[7:0];
        end
    end

    // Rate: half bit lasts HALF_MIN times setting plus one cycles
    assign rate_eff = (rate > 7'(RATE_STEPS - 1)) ? 7'(RATE_STEPS - 1) : rate;
    assign half_len = 8'({1'b0, rate_eff} + 8'h01) * 8'(HALF_MIN);

    // Role and edge events, master and slave alike
    assign master_on = ctrl.enable & ctrl.master;
    assign slave_on = ctrl.enable & ~ctrl.master & ~ste_s[1];
    assign busy = (state == ST_SHIFT);
    assign tick = busy && (half_cnt == half_len - 8'h01);
    assign m_lead = tick & (sclk_lvl == ctrl.pol);
    assign m_trail = tick & (sclk_lvl != ctrl.pol);
    assign s_edge = slave_on & (sclk_s[1] != sclk_prev);
    assign lead = m_lead | (s_edge & (sclk_s[1] != ctrl.pol));
    assign trail = m_trail | (s_edge & (sclk_s[1] == ctrl.pol));
    assign sample = m_samp_d |
                    (~ctrl.master & (ctrl.phase ? lead : trail));
    assign present = ctrl.phase ? trail : lead;
    assign tx_load = wr & hit(paddr, OFS_TXLO) & ~busy & ~m_samp_d;
    assign start = tx_load & master_on;
    assign slave_begin = ctrl.enable & ~ctrl.master & ste_prev & ~ste_s[1];
    assign din = ctrl.master ? somi_s[1] : simo_s[1];
    assign word_done = sample & (bit_cnt == len_m1);
    assign next_word = align({tx_data[15:8], pwdata[7:0]}, len_m1);
    assign edge_last = {len_m1, 1'b1};

    // Master samples one cycle after its own edge, so the synchronised
    // input has caught up with a bit changed at the opposite edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            m_samp_d <= 1'b0;
        else
            m_samp_d <= busy & (ctrl.phase ? m_lead : m_trail);
    end

    // Master engine state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ST_IDLE;
        else
            unique case (state)
                ST_IDLE:
                    if (start)
                        state <= ST_SHIFT;
                ST_SHIFT:
                    if (!master_on || (tick && edge_cnt == edge_last))
                        state <= ST_IDLE;
            endcase
    end

    // Half-period and edge counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_cnt <= 8'h00;
            edge_cnt <= 5'h00;
        end
        else
        begin
            half_cnt <= (!busy || tick) ? 8'h00 : half_cnt + 8'h01;
            if (!busy)
                edge_cnt <= 5'h00;
            else if (tick)
                edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // Shift clock level: idle at polarity, toggles each half bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sclk_lvl <= 1'b0;
        else if (!busy)
            sclk_lvl <= ctrl.pol;
        else if (tick)
            sclk_lvl <= ~sclk_lvl;
    end

    // Transmit shifter; delayed phase shows the first bit early
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_sr <= 16'h0000;
            out_bit <= 1'b0;
        end
        else if (start && ctrl.phase)
        begin
            out_bit <= next_word[15];
            tx_sr <= {next_word[14:0], 1'b0};
        end
        else if (tx_load)
            tx_sr <= next_word;
        else if (word_done && !ctrl.master)
            tx_sr <= align(tx_data, len_m1);
        else if (present || (slave_begin && ctrl.phase))
        begin
            out_bit <= tx_sr[15];
            tx_sr <= {tx_sr[14:0], 1'b0};
        end
    end

    // Receive shifter and bit counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_sr <= 16'h0000;
            bit_cnt <= 4'h0;
        end
        else
        begin
            if (sample)
                rx_sr <= {rx_sr[14:0], din};
            if (!ctrl.enable || start || (!ctrl.master && ste_s[1]))
                bit_cnt <= 4'h0;
            else if (sample)
                bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    // Received word, masked to the programmed length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_data <= 16'h0000;
        else if (word_done)
            rx_data <= {rx_sr[14:0], din} & (16'hFFFF >> (4'hF - len_m1));
    end

    // Sticky flags: set wins over the read that clears them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= 2'h0;
        else
        begin
            status <= (status & ~(access ? stat_cap : 2'h0)) |
                      {word_done, word_done};
        end
    end

    // Interrupt line and pin drivers
    assign irq = |(status & mask);
    assign serial_shift_clock_out = sclk_lvl;
    assign serial_shift_clock_oe = master_on;
    assign slave_in_master_out_out = out_bit;
    assign slave_in_master_out_oe = master_on & ctrl.tx_en;
    assign slave_out_master_in_out = out_bit;
    assign slave_out_master_in_oe = slave_on & ctrl.tx_en;
    assign port_in_use = ctrl.enable;

    // Helper: leading edges made during one master word
    logic [4:0] lead_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lead_cnt <= 5'h00;
        else if (start)
            lead_cnt <= 5'h00;
        else if (m_lead)
            lead_cnt <= lead_cnt + 5'h01;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_unmapped_err: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access without error");
    chk_pins_released: assert property (!ctrl.enable |->
        !serial_shift_clock_oe && !slave_in_master_out_oe &&
        !slave_out_master_in_oe)
        else $error("pins driven while port disabled");
    chk_slave_quiet: assert property (ste_s[1] |->
        !slave_out_master_in_oe)
        else $error("slave drives while transmit enable off");
    chk_master_dirs: assert property (master_on |->
        serial_shift_clock_oe && !slave_out_master_in_oe)
        else $error("master pin directions wrong");
    chk_tx_off: assert property (!ctrl.tx_en |->
        !slave_in_master_out_oe && !slave_out_master_in_oe)
        else $error("data driven with transmit off");
    chk_idle_level: assert property (master_on && !busy ##1 !busy |->
        serial_shift_clock_out == $past(ctrl.pol))
        else $error("shift clock not at idle level");
    chk_cycle_count: assert property ($fell(busy) && $past(master_on) |->
        lead_cnt == {1'b0, len_m1} + 5'h01)
        else $error("wrong number of shift clock cycles");
    chk_half_rate: assert property (busy && $changed(sclk_lvl) |=>
        !$changed(sclk_lvl))
        else $error("shift clock half period too short");
    chk_nodelay_edge: assert property (busy && !ctrl.phase &&
        $changed(out_bit) |-> sclk_lvl != ctrl.pol)
        else $error("data changed off leading edge");
    chk_delay_edge: assert property (busy && ctrl.phase &&
        $changed(out_bit) |-> sclk_lvl == ctrl.pol)
        else $error("delayed data changed off trailing edge");
    chk_irq_raise: assert property (word_done && mask[STAT_RX_BIT] |=>
        irq)
        else $error("interrupt not raised on done");

    cov_master_word: cover property ($fell(busy) && ctrl.phase);
    cov_slave_word: cover property (word_done && !ctrl.master);
    cov_irq: cover property ($rose(irq));
    cov_rx_only: cover property (word_done && !ctrl.tx_en);
endmodule

/* include/ssp_pkg.sv */
// Constants, field layouts and types of the synchronous serial port.
// Assumes an APB slave decode on a 16-bit byte address space.
package ssp_pkg;
    // Bus geometry and register frame
    localparam int ADDR_W = 16;
    localparam logic [15:0] FRAME_BASE = 16'h7040;
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_LEN = 6'h04;
    localparam logic [5:0] OFS_RATE = 6'h08;
    localparam logic [5:0] OFS_TXLO = 6'h0C;
    localparam logic [5:0] OFS_TXHI = 6'h10;
    localparam logic [5:0] OFS_RXLO = 6'h14;
    localparam logic [5:0] OFS_RXHI = 6'h18;
    localparam logic [5:0] OFS_STAT = 6'h1C;
    localparam logic [5:0] OFS_MASK = 6'h20;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] LEN_RST = 4'h7;
    localparam logic [6:0] RATE_RST = 7'h00;
    localparam logic [1:0] MASK_RST = 2'h0;

    // Status and mask bit positions
    localparam int STAT_RX_BIT = 0;
    localparam int STAT_TX_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;

    // Fastest rate: processor clock in MHz over top rate in kbit/s
    localparam int PROC_CLK_MHZ = 30;
    localparam int MAX_KBPS = 7500;
    localparam int HALF_MIN = PROC_CLK_MHZ * 1000 / MAX_KBPS / 2;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] rsvd;
        logic tx_en;
        logic phase;
        logic pol;
        logic master;
        logic enable;
    } ssp_ctrl_t;

    // Master shift engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } ssp_state_t;
endpackage

/* dv/ssp_far_end.sv */
// Far-end serial model: one word per call, as slave or as master.
// Assumes the bench resolves each pin from the port's output enables.
`timescale 1ns/1ps
module ssp_far_end (
    // Resolved pin levels
    input wire logic sclk_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    // Word setup
    input wire logic pol,
    input wire logic phase,
    input wire logic [4:0] len,
    input wire logic [15:0] tx_word,
    // Drives of this end
    output logic sclk_d,
    output logic mosi_d,
    output logic miso_d,
    output logic ste_n,
    output logic [15:0] rx_word
);
    // Idle: clock still, select off
    initial
    begin
        sclk_d = 1'b0;
        mosi_d = 1'b0;
        miso_d = 1'b0;
        ste_n = 1'b1;
        rx_word = 16'h0000;
    end

    // Slave to the port's clock, MSB first
    task automatic serve_word();
        rx_word = 16'h0000;
        for (int i = int'(len) - 1; i >= 0; i--)
        begin
            if (phase)
                miso_d = tx_word[i];
            wait (sclk_w !== pol);
            if (phase)
                rx_word = {rx_word[14:0], mosi_w};
            else
                miso_d = tx_word[i];
            wait (sclk_w === pol);
            if (!phase)
                rx_word = {rx_word[14:0], mosi_w};
        end
        miso_d = ~miso_d; // Released line keeps no stale bit
    endtask

    // Master with a 125 ns link clock that stands still between words
    task automatic drive_word();
        rx_word = 16'h0000;
        sclk_d = pol;
        #62.5;
        ste_n = 1'b0;
        for (int i = int'(len) - 1; i >= 0; i--)
        begin
            if (phase)
                mosi_d = tx_word[i];
            #62.5;
            sclk_d = ~pol;
            if (phase)
                rx_word = {rx_word[14:0], miso_w};
            else
                mosi_d = tx_word[i];
            #62.5;
            sclk_d = pol;
            if (!phase)
                rx_word = {rx_word[14:0], miso_w};
        end
        #62.5;
        ste_n = 1'b1;
        mosi_d = ~mosi_d;
    endtask
endmodule

/* dv/sync_serial_port_test.sv */
// Bench for the serial port: APB tasks, far-end model, word scenarios.
// Assumes ssp_pkg and the far-end model are compiled first.
`timescale 1ns/1ps
module sync_serial_port_test;
    import ssp_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, in_use;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic ck_o, ck_oe, si_o, si_oe, so_o, so_oe, rd_err, last_clk;
    logic ck_d, si_d, so_d, ste_n, f_pol, f_ph, ck_w, si_w, so_w;
    logic [4:0] f_len;
    logic [15:0] f_tx, f_rx;
    int fail_count, compares, edges, gap, gap_last, m;
    logic [5:0] ofs_tab [5] = '{OFS_CTRL, OFS_LEN, OFS_RATE, OFS_STAT,
        OFS_MASK};
    logic [31:0] rst_tab [5] = '{32'(CTRL_RST), 32'(LEN_RST),
        32'(RATE_RST), 32'h0000_0000, 32'(MASK_RST)};

    // Pin levels from the port's output enables
    assign ck_w = ck_oe ? ck_o : ck_d;
    assign si_w = si_oe ? si_o : si_d;
    assign so_w = so_oe ? so_o : so_d;

    always #5 pclk = ~pclk;

    ssp_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .serial_shift_clock_in(ck_w), .serial_shift_clock_out(ck_o),
        .serial_shift_clock_oe(ck_oe), .slave_in_master_out_in(si_w),
        .slave_in_master_out_out(si_o), .slave_in_master_out_oe(si_oe),
        .slave_out_master_in_in(so_w), .slave_out_master_in_out(so_o),
        .slave_out_master_in_oe(so_oe), .slave_transmit_enable_n(ste_n),
        .port_in_use(in_use)
    );
    ssp_far_end far_u (
        .sclk_w(ck_w), .mosi_w(si_w), .miso_w(so_w), .pol(f_pol),
        .phase(f_ph), .len(f_len), .tx_word(f_tx), .sclk_d(ck_d),
        .mosi_d(si_d), .miso_d(so_d), .ste_n(ste_n), .rx_word(f_rx)
    );

    // Count shift clock toggles and the spacing of the last two
    always @(posedge pclk)
    begin
        gap++;
        if (ck_oe === 1'b1 && ck_o !== last_clk)
        begin
            edges++;
            gap_last = gap;
            gap = 0;
        end
        last_clk = ck_o;
    end

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp,
        input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    // One APB transfer; the request holds until pready is seen high or 20 cycles pass
    task automatic apb(input logic wr, input logic [5:0] ofs,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= FRAME_BASE + {10'h000, ofs};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            fail_count++;
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] ofs, input logic [31:0] wd);
        apb(1'b1, ofs, wd);
    endtask

    task automatic rd_chk(input string what, input logic [5:0] ofs,
        input logic [31:0] exp);
        apb(1'b0, ofs, 32'h0000_0000);
        chk(what, exp, rd_data);
    endtask

    task automatic wait_irq();
        for (int n = 0; n < 20000 && irq !== 1'b1; n++)
            @(posedge pclk);
        chk_pin("irq at word end", 1'b1, irq);
    endtask

    // Port as master, far end as slave; mode is {phase, pol}
    task automatic master_word(input logic [1:0] mode, input int len,
        input int rate, input logic tx_on, input logic [15:0] dtx);
        logic [15:0] msk;
        msk = 16'((32'h1 << len) - 1);
        f_pol = mode[0];
        f_ph = mode[1];
        f_len = 5'(len);
        f_tx = ~dtx;
        wr(OFS_CTRL, {27'h0, tx_on, mode, 2'b11});
        wr(OFS_LEN, 32'(len - 1));
        wr(OFS_RATE, 32'(rate));
        wr(OFS_MASK, 32'h0000_0003);
        wr(OFS_TXHI, {24'h0, dtx[15:8]});
        @(negedge pclk);
        chk("master enables", {29'h0, 1'b1, tx_on, 1'b0},
            {29'h0, ck_oe, si_oe, so_oe});
        chk_pin("pins in use", 1'b1, in_use);
        edges = 0;
        fork
            far_u.serve_word();
            begin
                wr(OFS_TXLO, {24'h0, dtx[7:0]});
                if (rate != 0)
                    rd_chk("busy", OFS_STAT, 32'h0000_0004);
                wait_irq();
            end
        join
        repeat (2) @(negedge pclk);
        chk("clock edges", 32'(2 * len), 32'(edges));
        chk_pin("clock idle", mode[0], ck_o);
        chk("half period", (rate > 124) ? 32'd250 : 32'(2 * (rate + 1)),
            32'(gap_last));
        if (tx_on)
            chk("far word", {16'h0, dtx & msk}, {16'h0, f_rx});
        rd_chk("rx low", OFS_RXLO, {24'h0, f_tx[7:0] & msk[7:0]});
        rd_chk("rx high", OFS_RXHI, {24'h0, f_tx[15:8] & msk[15:8]});
        rd_chk("status", OFS_STAT, 32'h0000_0003);
        @(negedge pclk);
        chk_pin("irq cleared", 1'b0, irq);
    endtask

    // Port as slave of the far end's 16-bit word
    task automatic slave_word(input logic [1:0] mode, input logic [15:0] dtx);
        f_pol = mode[0];
        f_ph = mode[1];
        f_len = 5'd16;
        f_tx = dtx ^ 16'h0FF0;
        wr(OFS_CTRL, {27'h0, 1'b1, mode, 2'b01});
        wr(OFS_LEN, 32'h0000_000F);
        wr(OFS_TXHI, {24'h0, dtx[15:8]});
        wr(OFS_TXLO, {24'h0, dtx[7:0]});
        @(negedge pclk);
        chk("slave enables", 32'h0, {29'h0, ck_oe, si_oe, so_oe});
        fork
            far_u.drive_word();
            begin
                repeat (30) @(negedge pclk);
                chk_pin("slave out selected", 1'b1, so_oe);
            end
        join
        wait_irq();
        repeat (3) @(negedge pclk);
        chk_pin("slave out released", 1'b0, so_oe);
        chk("far word", {16'h0, dtx}, {16'h0, f_rx});
        rd_chk("rx low", OFS_RXLO, {24'h0, f_tx[7:0]});
        rd_chk("rx high", OFS_RXHI, {24'h0, f_tx[15:8]});
        rd_chk("status", OFS_STAT, 32'h0000_0003);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog against a hung handshake or word
    initial
    begin
        #1000000;
        fail_count++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {f_pol, f_ph, f_len, f_tx, gap, gap_last, last_clk} = '0;
        {fail_count, compares, edges} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("pins at reset", 32'h0, {28'h0, in_use, ck_oe, si_oe, so_oe});
        for (m = 0; m < 5; m++)
            rd_chk("reset value", ofs_tab[m], rst_tab[m]);
        apb(1'b0, 6'h24, 32'h0000_0000);
        chk("unmapped", 32'h1, {rd_data[30:0], rd_err});
        wr(OFS_LEN, 32'h0000_AB05);
        rd_chk("upper byte", OFS_LEN, 32'h0000_0005);
        wr(OFS_CTRL, 32'h0000_FF00);
        rd_chk("upper ctrl", OFS_CTRL, 32'h0000_0000);
        for (m = 0; m < 4; m++)
        begin
            master_word(2'(m), 1, 0, 1'b1, 16'hA5C3 ^ 16'(m));
            master_word(2'(m), 16, 0, 1'b1, 16'h96E1 + 16'(m));
        end
        master_word(2'b00, 16, 127, 1'b1, 16'h1234);
        master_word(2'b01, 8, 2, 1'b0, 16'h00C3);
        // Masked events keep irq low; unmasking shows them
        wr(OFS_MASK, 32'h0000_0000);
        edges = 0;
        wr(OFS_TXLO, 32'h0000_005A);
        for (m = 0; m < 500 && edges < 16; m++)
            @(posedge pclk);
        repeat (3) @(negedge pclk);
        chk_pin("irq masked", 1'b0, irq);
        wr(OFS_MASK, 32'h0000_0001);
        @(negedge pclk);
        chk_pin("irq unmasked", 1'b1, irq);
        rd_chk("status", OFS_STAT, 32'h0000_0003);
        @(negedge pclk);
        chk_pin("irq after read", 1'b0, irq);
        for (m = 0; m < 4; m++)
            slave_word(2'(m), 16'hC35A ^ 16'(m));
        give_verdict();
    end
endmodule
